// ### edl_deser_lock.sv
// Deserializer top: pin sync, operating states, word crossing, recovered clock and output enables
//
// Summary of operation
// - Serial stream becomes 10-bit words plus clock
// - Three active and three passive operating states
// - Outputs float while held in power-up
// - Lock indicator high while still acquiring
// - Locks on random data or sync patterns
// - Transitions start lock attempt; lock drives low
// - Twelve bits per word, ten carry data
// - Words valid only while lock is low
// - Edge select picks the data reference edge
// - Lock loss: indicator high, data and clock float
// - Sleep when request and enable both low; from power-up the block stays in power-up instead
// - Enable low floats data, lock and clock
// - After sleep, reinitialise; lock high until relocked
`timescale 1ns/100ps
module edl_deser_lock import edl_pkg::*; #(
   parameter int LOCK_WORDS = LOCK_WORDS_DEF
) (
   // System clock (local reference) and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Serial link
   input wire logic link_bit_clk_in,
   input wire logic serial_data_in,
   // Control pins
   input wire logic sleep_request_n_in,
   input wire logic output_enable_in,
   input wire logic edge_rise_sel_in,
   // Parallel word and recovered clock
   output logic [WORD_BITS-1:0] parallel_word_out,
   output logic word_oe_out,
   output logic recovered_clk_out,
   output logic rclk_oe_out,
   // Lock indicator
   output logic lock_n_out,
   output logic lock_oe_out
);
   logic [WORD_BITS-1:0] link_word;
   logic link_tgl, link_locked;
   logic sleep_meta_q, sleep_n_q;
   logic oe_meta_q, oe_q;
   logic edge_meta_q, edge_q;
   logic lock_meta_q, lock_q;
   logic tgl_meta_q, tgl_s1_q, tgl_s2_q;
   logic word_cap;
   logic run_q;
   logic rclk_q;
   logic [WORD_BITS-1:0] word_q;
   edl_state_e state_q, state_d;

   edl_word_aligner #(
      .LOCK_WORDS(LOCK_WORDS)
   ) u_aligner (
      .lclk_in(link_bit_clk_in),
      .rst_in(sys_rst_in),
      .run_in(run_q),
      .serial_in(serial_data_in),
      .word_out(link_word),
      .word_tgl_out(link_tgl),
      .locked_out(link_locked)
   );

   // Pins and link-domain levels pass two flops before use
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         sleep_meta_q <= 1'h0;
         sleep_n_q <= 1'h0;
         oe_meta_q <= 1'h0;
         oe_q <= 1'h0;
         edge_meta_q <= 1'h0;
         edge_q <= 1'h0;
      end else begin
         sleep_meta_q <= sleep_request_n_in;
         sleep_n_q <= sleep_meta_q;
         oe_meta_q <= output_enable_in;
         oe_q <= oe_meta_q;
         edge_meta_q <= edge_rise_sel_in;
         edge_q <= edge_meta_q;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         lock_meta_q <= 1'h0;
         lock_q <= 1'h0;
         tgl_meta_q <= 1'h0;
         tgl_s1_q <= 1'h0;
         tgl_s2_q <= 1'h0;
      end else begin
         lock_meta_q <= link_locked;
         lock_q <= lock_meta_q;
         tgl_meta_q <= link_tgl;
         tgl_s1_q <= tgl_meta_q;
         tgl_s2_q <= tgl_s1_q;
      end
   end

   // The link word is held for a full frame (12 link bits), far longer than the toggle takes to cross
   assign word_cap = tgl_s1_q ^ tgl_s2_q;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_POWERUP: begin
            if (sleep_n_q) begin
               state_d = ST_INIT;
            end
         end
         ST_SLEEP: begin
            if (sleep_n_q) begin
               state_d = ST_INIT;
            end
         end
         ST_INIT, ST_XFER, ST_RESYNC, ST_HIGHZ: begin
            if (!sleep_n_q && !oe_q) begin
               state_d = ST_SLEEP;
            end else if (!oe_q) begin
               state_d = ST_HIGHZ;
            end else if (state_q == ST_HIGHZ) begin
               state_d = lock_q ? ST_XFER : ST_INIT;
            end else if (lock_q) begin
               state_d = ST_XFER;
            end else if (state_q == ST_XFER) begin
               state_d = ST_RESYNC;
            end
         end
         default: begin
            state_d = ST_POWERUP;
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_q <= ST_POWERUP;
      end else begin
         state_q <= state_d;
      end
   end

   // The loop is stopped in power-up and sleep, which also clears any stale lock
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         run_q <= 1'h0;
      end else begin
         run_q <= (state_d != ST_POWERUP) && (state_d != ST_SLEEP);
      end
   end

   // Data changes as the clock leaves its idle level on the unselected edge; the selected edge follows one cycle later
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         word_q <= WORD_RST_VAL;
         rclk_q <= 1'h0;
      end else if (word_cap) begin
         word_q <= link_word;
         rclk_q <= ~edge_q;
      end else begin
         rclk_q <= edge_q;
      end
   end

   assign parallel_word_out = word_q;
   assign recovered_clk_out = rclk_q;
   assign word_oe_out = (state_q == ST_XFER);
   assign rclk_oe_out = (state_q == ST_XFER);
   assign lock_n_out = (state_q != ST_XFER);
   assign lock_oe_out = (state_q == ST_INIT) || (state_q == ST_XFER) || (state_q == ST_RESYNC);

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   a_powerup_float: assert property (
      state_q == ST_POWERUP |-> !word_oe_out && !rclk_oe_out && !lock_oe_out)
      else $error("outputs driven during power-up");
   a_acquire_high: assert property (
      state_q == ST_INIT |-> lock_n_out && lock_oe_out)
      else $error("lock indicator low while acquiring");
   a_lock_goes_low: assert property (
      state_q == ST_INIT && lock_q && oe_q && sleep_n_q |=> !lock_n_out && word_oe_out)
      else $error("lock not reported after acquisition");
   a_valid_only_lock: assert property (
      word_oe_out |-> !lock_n_out && lock_oe_out)
      else $error("word driven without lock");
   a_loss_floats: assert property (
      state_q == ST_XFER && !lock_q && oe_q |=> lock_n_out && lock_oe_out && !word_oe_out && !rclk_oe_out)
      else $error("lock loss not handled");
   a_sleep_entry: assert property (
      state_q != ST_POWERUP && !sleep_n_q && !oe_q |=> state_q == ST_SLEEP && !lock_oe_out && !run_q)
      else $error("sleep not entered");
   a_enable_floats: assert property (
      state_q inside {ST_INIT, ST_XFER, ST_RESYNC} && !oe_q |=> !lock_oe_out && !word_oe_out && !rclk_oe_out)
      else $error("enable low did not float outputs");
   a_sleep_exit: assert property (
      state_q == ST_SLEEP && sleep_n_q |=> state_q == ST_INIT && lock_n_out && run_q)
      else $error("sleep exit did not reinitialise");
   a_word_capture: assert property (
      word_cap |=> parallel_word_out == $past(link_word))
      else $error("word not captured");
   a_rclk_edge: assert property (
      word_cap ##1 !word_cap |-> recovered_clk_out != $past(edge_q) ##1 recovered_clk_out == $past(edge_q))
      else $error("recovered clock edge wrong");
   a_state_legal: assert property (
      state_q inside {ST_POWERUP, ST_INIT, ST_XFER, ST_RESYNC, ST_SLEEP, ST_HIGHZ})
      else $error("illegal state");

   c_first_lock: cover property (state_q == ST_INIT ##1 state_q == ST_XFER);
   c_resync: cover property (state_q == ST_XFER ##1 state_q == ST_RESYNC ##[1:1000] state_q == ST_XFER);
   c_sleep_cycle: cover property (state_q == ST_SLEEP ##1 state_q == ST_INIT);
   c_highz_back: cover property (state_q == ST_HIGHZ ##1 state_q == ST_XFER);
endmodule

// ### edl_pkg.sv
// Shared constants, state encoding and frame decoding for the deserializer lock block
package edl_pkg;
   localparam int WORD_BITS = 10;
   localparam int FRAME_BITS = 12;
   localparam logic [3:0] LAST_BIT = 4'h0 + 4'(FRAME_BITS - 1);
   localparam int LOCK_WORDS_DEF = 8;
   localparam int SYNC_PATTERNS_MIN = 1024;
   localparam int TX_CLK_MIN_MHZ = 16;
   localparam int TX_CLK_MAX_MHZ = 40;
   localparam int CLK_PERIOD_NS = 100;
   localparam logic WORD_RST = 1'h0;
   localparam logic [WORD_BITS-1:0] WORD_RST_VAL = 10'h000;

   typedef enum logic [2:0] {
      ST_POWERUP = 3'h0,
      ST_INIT = 3'h1,
      ST_XFER = 3'h2,
      ST_RESYNC = 3'h3,
      ST_SLEEP = 3'h4,
      ST_HIGHZ = 3'h5
   } edl_state_e;

   // Frame as shifted in: [11] leading clock bit (1), [10:1] data bit 0..9, [0] trailing clock bit (0)
   function automatic logic edl_frame_ok(input logic [FRAME_BITS-1:0] f);
      edl_frame_ok = f[FRAME_BITS-1] & ~f[0];
   endfunction

   function automatic logic [WORD_BITS-1:0] edl_frame_data(input logic [FRAME_BITS-1:0] f);
      logic [WORD_BITS-1:0] d;
      d = '0;
      for (int i = 0; i < WORD_BITS; i++) begin
         d[i] = f[FRAME_BITS-2-i];
      end
      edl_frame_data = d;
   endfunction
endpackage

// ### edl_word_aligner.sv
// Link-clock word aligner: hunts for the embedded clock bits and emits 10-bit words
`timescale 1ns/100ps
module edl_word_aligner import edl_pkg::*; #(
   parameter int LOCK_WORDS = LOCK_WORDS_DEF
) (
   // Link clock and reset
   input wire logic lclk_in,
   input wire logic rst_in,
   // Control from the system domain
   input wire logic run_in,
   // Serial stream
   input wire logic serial_in,
   // Recovered words
   output logic [WORD_BITS-1:0] word_out,
   output logic word_tgl_out,
   output logic locked_out
);
   localparam int CW = $clog2(LOCK_WORDS + 1);
   localparam logic [CW-1:0] LOCK_CNT = CW'(LOCK_WORDS);

   logic run_meta_q, run_q;
   logic serial_q;
   logic [FRAME_BITS-1:0] shift_q, shift_d;
   logic [3:0] bit_cnt_q;
   logic [CW-1:0] match_q;
   logic frame_end, frame_good;

   always_ff @(posedge lclk_in or posedge rst_in) begin
      if (rst_in) begin
         run_meta_q <= 1'h0;
         run_q <= 1'h0;
      end else begin
         run_meta_q <= run_in;
         run_q <= run_meta_q;
      end
   end

   always_ff @(posedge lclk_in or posedge rst_in) begin
      if (rst_in) begin
         serial_q <= 1'h0;
         shift_q <= '0;
      end else begin
         serial_q <= serial_in;
         shift_q <= shift_d;
      end
   end

   assign shift_d = {shift_q[FRAME_BITS-2:0], serial_q};
   assign frame_end = run_q && (bit_cnt_q == LAST_BIT);
   assign frame_good = edl_frame_ok(shift_d);

   // A bad frame holds the counter one bit longer, so the boundary guess slides by one bit
   always_ff @(posedge lclk_in or posedge rst_in) begin
      if (rst_in) begin
         bit_cnt_q <= 4'h0;
         match_q <= '0;
         locked_out <= 1'h0;
      end else if (!run_q) begin
         bit_cnt_q <= 4'h0;
         match_q <= '0;
         locked_out <= 1'h0;
      end else if (frame_end) begin
         if (frame_good) begin
            bit_cnt_q <= 4'h0;
            if (match_q != LOCK_CNT) begin
               match_q <= match_q + CW'(1);
            end
            locked_out <= (match_q >= LOCK_CNT - CW'(1));
         end else begin
            match_q <= '0;
            locked_out <= 1'h0;
         end
      end else begin
         bit_cnt_q <= bit_cnt_q + 4'h1;
      end
   end

   always_ff @(posedge lclk_in or posedge rst_in) begin
      if (rst_in) begin
         word_out <= WORD_RST_VAL;
         word_tgl_out <= 1'h0;
      end else if (frame_end && frame_good && match_q >= LOCK_CNT - CW'(1)) begin
         word_out <= edl_frame_data(shift_d);
         word_tgl_out <= ~word_tgl_out;
      end
   end

   a_hunt_drop: assert property (@(posedge lclk_in) disable iff (rst_in)
      frame_end && !frame_good |=> !locked_out && match_q == '0)
      else $error("lock kept after a bad frame");
   a_frame_period: assert property (@(posedge lclk_in) disable iff (rst_in || !run_q)
      frame_end && frame_good |=> bit_cnt_q == 4'h0 ##11 bit_cnt_q == LAST_BIT)
      else $error("frame is not twelve bits long");
   a_lock_after_run: assert property (@(posedge lclk_in) disable iff (rst_in)
      $rose(locked_out) |-> $past(frame_good) && $past(match_q) >= LOCK_CNT - CW'(1))
      else $error("lock without enough good frames");
   c_word_emit: cover property (@(posedge lclk_in) disable iff (rst_in) $changed(word_tgl_out));
endmodule

// ### edl_serializer_model.sv
// Serializer model: frames words with embedded clock bits, sends sync words on request
`timescale 1ns/100ps
module edl_serializer_model import edl_pkg::*; #(
   parameter logic [WORD_BITS-1:0] SYNC_WORD = 10'h01F
) (
   // Link clock
   input wire logic bit_clk_in,
   // Word source and control
   input wire logic [WORD_BITS-1:0] data_word_in,
   input wire logic pattern_request_a_in,
   input wire logic pattern_request_b_in,
   input wire logic bad_frame_in,
   // Serial line
   output logic serial_out
);
   logic [3:0] pos_q = 4'h0;
   int pat_left_q = 0;
   logic [FRAME_BITS-1:0] frame_q = '0;
   logic [WORD_BITS-1:0] word_q;
   // Bits launched on the falling edge so the receiver samples them mid-cell
   always @(negedge bit_clk_in) begin
      if (pos_q == 4'h0) begin
         if (pattern_request_a_in || pattern_request_b_in) pat_left_q = SYNC_PATTERNS_MIN;
         word_q = (pat_left_q > 0) ? SYNC_WORD : data_word_in;
         if (pat_left_q > 0) pat_left_q = pat_left_q - 1;
         frame_q[FRAME_BITS-1] = 1'h1;
         for (int i = 0; i < WORD_BITS; i++) frame_q[FRAME_BITS-2-i] = word_q[i];
         // Trailing clock bit forced high only when a broken frame is commanded
         frame_q[0] = bad_frame_in;
      end
      serial_out <= frame_q[FRAME_BITS-1-int'(pos_q)];
      pos_q <= (pos_q == LAST_BIT) ? 4'h0 : pos_q + 4'h1;
   end
endmodule

// ### tb_edl_deser_lock.sv
// Self-checking bench for the deserializer lock block driven by a serializer model
`timescale 1ns/100ps
module tb_edl_deser_lock;
   import edl_pkg::*;
   localparam logic [WORD_BITS-1:0] SYNC_W = 10'h01F;
   typedef struct packed {logic sel; logic [WORD_BITS-1:0] word;} edl_row_s;
   edl_row_s rows[4] = '{'{1'h1, 10'h3FF}, '{1'h0, 10'h000}, '{1'h1, 10'h2A5}, '{1'h0, 10'h15A}};
   logic clk = 1'h0;
   logic link_clk = 1'h0;
   logic rst = 1'h1;
   logic sleep_n = 1'h0;
   logic oe = 1'h1;
   logic rise_sel = 1'h1;
   logic req_a = 1'h0;
   logic req_b = 1'h0;
   logic bad = 1'h0;
   logic [WORD_BITS-1:0] tx_word = SYNC_W;
   logic serial;
   logic [WORD_BITS-1:0] par_word;
   logic word_oe, rclk, rclk_oe, lock_n, lock_oe;
   int miscompares = 0;
   int checks = 0;

   initial begin
      forever #50 clk = ~clk;
   end
   // Link bit clock in its own phase; the word clock it implies is scaled down for simulation
   initial begin
      #13;
      forever #40 link_clk = ~link_clk;
   end

   edl_serializer_model #(.SYNC_WORD(SYNC_W)) i_edl_serializer_model (.bit_clk_in(link_clk),
      .data_word_in(tx_word), .pattern_request_a_in(req_a), .pattern_request_b_in(req_b),
      .bad_frame_in(bad), .serial_out(serial));

   edl_deser_lock #(.LOCK_WORDS(4)) i_edl_deser_lock (.clk_in(clk), .sys_rst_in(rst),
      .link_bit_clk_in(link_clk), .serial_data_in(serial), .sleep_request_n_in(sleep_n),
      .output_enable_in(oe), .edge_rise_sel_in(rise_sel), .parallel_word_out(par_word),
      .word_oe_out(word_oe), .recovered_clk_out(rclk), .rclk_oe_out(rclk_oe),
      .lock_n_out(lock_n), .lock_oe_out(lock_oe));

   task automatic complete_run();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk_bit(input string name, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic chk_word(input string name, input logic [WORD_BITS-1:0] exp, input logic [WORD_BITS-1:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic chk_float(input logic lock_drive);
      chk_bit("word enable", 1'h0, word_oe);
      chk_bit("clock enable", 1'h0, rclk_oe);
      chk_bit("lock enable", lock_drive, lock_oe);
   endtask

   task automatic wait_lock(input logic lv, input int bound);
      int n;
      n = 0;
      while (lock_n !== lv && n < bound) begin
         @(negedge clk);
         n++;
      end
      chk_bit("lock wait", lv, lock_n);
      if (lock_n !== lv) complete_run();
   endtask

   // Counts reference edges: recovered clock returning to the selected level
   task automatic wait_edges(input int k);
      int n;
      logic prev;
      n = 0;
      prev = rclk;
      while (k > 0 && n < 200) begin
         @(negedge clk);
         if (rclk === rise_sel && prev === ~rise_sel) k--;
         prev = rclk;
         n++;
      end
      chk_bit("recovered clock edges", 1'h1, k == 0);
      if (k > 0) complete_run();
   endtask

   initial begin
      tick(12);
      chk_float(1'h0);
      chk_bit("lock", 1'h1, lock_n);
      rst = 1'h0;
      tick(20);
      chk_float(1'h0);
      sleep_n = 1'h1;
      tick(5);
      chk_bit("lock enable", 1'h1, lock_oe);
      chk_bit("lock", 1'h1, lock_n);
      wait_lock(1'h0, 1000);
      foreach (rows[i]) begin
         rise_sel = rows[i].sel;
         tx_word = rows[i].word;
         // A select change can show one false edge, and two older words may still be in flight
         wait_edges(5);
         chk_word("parallel word", rows[i].word, par_word);
         chk_bit("word enable", 1'h1, word_oe);
         chk_bit("lock", 1'h0, lock_n);
      end
      // A broken frame must drop lock; the monotone word keeps the hunt unambiguous
      tx_word = SYNC_W;
      tick(12);
      bad = 1'h1;
      tick(10);
      bad = 1'h0;
      wait_lock(1'h1, 100);
      tick(1);
      chk_float(1'h1);
      req_a = 1'h1;
      wait_lock(1'h0, 1000);
      wait_edges(3);
      chk_word("sync word", SYNC_W, par_word);
      tick(9900);
      req_a = 1'h0;
      oe = 1'h0;
      tick(5);
      chk_float(1'h0);
      oe = 1'h1;
      tick(5);
      chk_bit("word enable", 1'h1, word_oe);
      chk_bit("lock", 1'h0, lock_n);
      sleep_n = 1'h0;
      oe = 1'h0;
      tick(5);
      chk_float(1'h0);
      tick(20);
      req_b = 1'h1;
      sleep_n = 1'h1;
      oe = 1'h1;
      tick(5);
      chk_bit("lock enable", 1'h1, lock_oe);
      chk_bit("lock", 1'h1, lock_n);
      // Enable dropped while still hunting must come back to initialisation, not transfer
      oe = 1'h0;
      tick(5);
      chk_float(1'h0);
      oe = 1'h1;
      tick(5);
      chk_bit("lock enable", 1'h1, lock_oe);
      chk_bit("lock", 1'h1, lock_n);
      wait_lock(1'h0, 1000);
      req_b = 1'h0;
      // Reset in mid-run while locked: everything floats, then a fresh lock
      rst = 1'h1;
      tick(3);
      chk_float(1'h0);
      chk_bit("lock", 1'h1, lock_n);
      rst = 1'h0;
      tick(5);
      chk_bit("lock enable", 1'h1, lock_oe);
      chk_bit("lock", 1'h1, lock_n);
      wait_lock(1'h0, 1000);
      complete_run();
   end
endmodule
